/* File: logic/bau_consts.svh */
// Constants of the byte arithmetic unit: offsets, fields, resets, timing
`ifndef BAU_CONSTS_SVH
`define BAU_CONSTS_SVH
`define BAU_OFF_ACC      12'h0000
`define BAU_OFF_OPERAND  12'h0004
`define BAU_OFF_CTRL     12'h0008
`define BAU_OFF_FLAGS    12'h000C
`define BAU_OFF_MDREG    12'h00F0
`define BAU_FLD_CY       0
`define BAU_FLD_AC       1
`define BAU_FLD_OV       2
`define BAU_FLD_BUSY     3
`define BAU_FLD_SRC_LO   4
`define BAU_CTRL_GO      3
`define BAU_RST_BYTE     8'h00
`define BAU_DIV_STEPS    4'h8
`endif

/* File: logic/bau_pkg.sv */
// Types of the byte arithmetic unit
package bau_pkg;
    typedef enum logic [2:0] {
        BAU_OP_ADD  = 3'h0,
        BAU_OP_SUM_WITH_CARRY_OP = 3'h1,
        BAU_OP_DIFFERENCE_WITH_BORROW_OP = 3'h2,
        BAU_OP_MUL  = 3'h3,
        BAU_OP_DIV  = 3'h4
    } bau_op_t;
    typedef enum logic [1:0] {
        BAU_SRC_IMM = 2'h0,
        BAU_SRC_RAM = 2'h1,
        BAU_SRC_REG = 2'h2
    } bau_src_t;
    typedef enum logic [1:0] {
        BAU_ST_IDLE = 2'b01,
        BAU_ST_DIV  = 2'b10
    } bau_state_t;
    typedef struct packed {
        logic cy;
        logic ac;
        logic ov;
    } bau_flags_t;
    typedef struct packed {
        logic [11:0] paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } bau_apb_req_t;
endpackage

/* File: logic/bau_unit.sv */
// Byte arithmetic unit with APB register access
`timescale 1ns/10ps
`default_nettype none
`include "bau_consts.svh"

// Operation
// - Add writes the 8-bit sum of accumulator and operand back into the accumulator.
// - The second operand is an immediate, a direct RAM byte or a working register.
// - Add with carry also adds the carry flag; plain add ignores it.
// - Both adds set carry when the unsigned sum passes 8 bits and clear it otherwise.
// - Adds set the nibble carry on a carry out of bit 3 and clear it otherwise.
// - Adds set overflow when carries out of bit 7 and bit 6 differ.
// - Subtract writes accumulator minus operand minus carry into the accumulator.
// - Subtract sets carry when a borrow into bit 7 is needed.
// - Subtract sets the nibble carry when bit 3 needs a borrow.
// - Subtract sets overflow when borrows into bit 7 and bit 6 differ.
// - Multiply puts the low product byte in the accumulator and the high byte in B.
// - Multiply sets overflow above 255, clears carry, keeps the nibble carry.
// - Divide puts the quotient in the accumulator and the remainder in B.
// - Divide clears carry and overflow, but a zero divisor sets overflow.
module bau_unit
    import bau_pkg::*;
(
    // Clock and reset
    input  wire logic        I_MCLK,
    input  wire logic        I_NRST,
    // APB slave
    input  wire logic [11:0] I_PADDR,
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [31:0] I_PWDATA,
    // Operand sources
    input  wire logic [7:0]  I_RAM_BYTE,
    input  wire logic [7:0]  I_WORK_REG,
    // APB answer
    output logic [31:0]      O_PRDATA,
    output logic             O_PREADY,
    output logic             O_PSLVERR
);

    ////////////////////////////////////////////////////////////////////////
    logic [7:0]  acc_q,  acc_d;
    logic [7:0]  mdreg_q, mdreg_d;
    logic [7:0]  imm_q,  imm_d;
    bau_src_t    src_q,  src_d;
    bau_flags_t  flg_q,  flg_d;
    bau_state_t  st_q,   st_d;
    logic [3:0]  cnt_q,  cnt_d;
    logic [7:0]  rem_q,  rem_d;
    logic [7:0]  quo_q,  quo_d;
    logic [7:0]  ram_s1_q, ram_s2_q;
    logic [7:0]  reg_s1_q, reg_s2_q;
    logic [31:0] prdata_q, prdata_d;
    logic        pready_q, pready_d;
    logic        pslverr_q, pslverr_d;
    logic        done_q, done_d;

    logic [7:0]  opnd;
    logic        wr_acc, wr_op, wr_ctrl, wr_fl, wr_md, known;
    logic [8:0]  sum9;
    logic [4:0]  lo5;
    logic [7:0]  lo8;
    logic [15:0] prod;
    logic [8:0]  trial;
    logic        cin;
    bau_op_t     op;

    // Operand pins come from another domain and pass two flops first
    always_ff @(posedge I_MCLK) begin
        ram_s1_q <= I_RAM_BYTE;
        ram_s2_q <= ram_s1_q;
        reg_s1_q <= I_WORK_REG;
        reg_s2_q <= reg_s1_q;
    end

    always_comb begin
        case (src_q)
            BAU_SRC_RAM: opnd = ram_s2_q;
            BAU_SRC_REG: opnd = reg_s2_q;
            default:     opnd = imm_q;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Access phase with zero wait states; writes land at penable unless a divide runs
    always_comb begin
        known   = (I_PADDR == `BAU_OFF_ACC) || (I_PADDR == `BAU_OFF_OPERAND) ||
                  (I_PADDR == `BAU_OFF_CTRL) || (I_PADDR == `BAU_OFF_FLAGS) ||
                  (I_PADDR == `BAU_OFF_MDREG);
        wr_acc  = I_PSEL && I_PENABLE && I_PWRITE && (I_PADDR == `BAU_OFF_ACC);
        wr_op   = I_PSEL && I_PENABLE && I_PWRITE && (I_PADDR == `BAU_OFF_OPERAND);
        wr_ctrl = I_PSEL && I_PENABLE && I_PWRITE && (I_PADDR == `BAU_OFF_CTRL);
        wr_fl   = I_PSEL && I_PENABLE && I_PWRITE && (I_PADDR == `BAU_OFF_FLAGS);
        wr_md   = I_PSEL && I_PENABLE && I_PWRITE && (I_PADDR == `BAU_OFF_MDREG);
        op      = bau_op_t'(I_PWDATA[2:0]);
        pready_d  = I_PSEL && !I_PENABLE;
        pslverr_d = I_PSEL && !I_PENABLE && !known;
        prdata_d  = 32'h0000_0000;
        if (I_PSEL && !I_PENABLE && !I_PWRITE) begin
            case (I_PADDR)
                `BAU_OFF_ACC:     prdata_d = {24'h00_0000, acc_q};
                `BAU_OFF_OPERAND: prdata_d = {22'h00_0000, src_q, imm_q};
                `BAU_OFF_FLAGS:   prdata_d = {28'h000_0000, st_q == BAU_ST_DIV, flg_q.ov, flg_q.ac, flg_q.cy};
                `BAU_OFF_MDREG:   prdata_d = {24'h00_0000, mdreg_q};
                default:          prdata_d = 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Arithmetic core; writes while a divide runs are ignored
    always_comb begin
        acc_d   = acc_q;
        mdreg_d = mdreg_q;
        imm_d   = imm_q;
        src_d   = src_q;
        flg_d   = flg_q;
        st_d    = st_q;
        cnt_d   = cnt_q;
        rem_d   = rem_q;
        quo_d   = quo_q;
        done_d  = 1'b0;
        cin   = (op == BAU_OP_ADD) ? 1'b0 : flg_q.cy;
        sum9  = 9'h000;
        lo5   = 5'h00;
        lo8   = 8'h00;
        prod  = 16'h0000;
        trial = {rem_q, quo_q[7]} - {1'b0, mdreg_q};
        case (st_q)
            BAU_ST_IDLE: begin
                if (wr_acc) acc_d = I_PWDATA[7:0];
                if (wr_md) mdreg_d = I_PWDATA[7:0];
                if (wr_fl) begin
                    // Register bit positions, not the struct order, place each flag
                    flg_d.cy = I_PWDATA[`BAU_FLD_CY];
                    flg_d.ac = I_PWDATA[`BAU_FLD_AC];
                    flg_d.ov = I_PWDATA[`BAU_FLD_OV];
                end
                if (wr_op) begin
                    imm_d = I_PWDATA[7:0];
                    src_d = bau_src_t'(I_PWDATA[9:8]);
                end
                if (wr_ctrl && I_PWDATA[`BAU_CTRL_GO]) begin
                    case (op)
                        BAU_OP_ADD, BAU_OP_SUM_WITH_CARRY_OP: begin
                            sum9  = {1'b0, acc_q} + {1'b0, opnd} + {8'h00, cin};
                            lo5   = {1'b0, acc_q[3:0]} + {1'b0, opnd[3:0]} + {4'h0, cin};
                            lo8   = {1'b0, acc_q[6:0]} + {1'b0, opnd[6:0]} + {7'h00, cin};
                            acc_d = sum9[7:0];
                            flg_d.cy = sum9[8];
                            flg_d.ac = lo5[4];
                            // carry 7 differs from carry 6
                            flg_d.ov = sum9[8] ^ lo8[7];
                            done_d = 1'b1;
                        end
                        BAU_OP_DIFFERENCE_WITH_BORROW_OP: begin
                            sum9  = {1'b0, acc_q} - {1'b0, opnd} - {8'h00, flg_q.cy};
                            lo5   = {1'b0, acc_q[3:0]} - {1'b0, opnd[3:0]} - {4'h0, flg_q.cy};
                            lo8   = {1'b0, acc_q[6:0]} - {1'b0, opnd[6:0]} - {7'h00, flg_q.cy};
                            acc_d = sum9[7:0];
                            flg_d.cy = sum9[8];
                            flg_d.ac = lo5[4];
                            flg_d.ov = sum9[8] ^ lo8[7];
                            done_d = 1'b1;
                        end
                        BAU_OP_MUL: begin
                            // low byte to acc, high to B
                            prod    = acc_q * mdreg_q;
                            acc_d   = prod[7:0];
                            mdreg_d = prod[15:8];
                            flg_d.ov = |prod[15:8];
                            flg_d.cy = 1'b0;
                            done_d = 1'b1;
                        end
                        BAU_OP_DIV: begin
                            // zero divisor sets overflow, values left as they are
                            if (mdreg_q == `BAU_RST_BYTE) begin
                                flg_d.cy = 1'b0;
                                flg_d.ov = 1'b1;
                                done_d = 1'b1;
                            end else begin
                                st_d  = BAU_ST_DIV;
                                cnt_d = `BAU_DIV_STEPS;
                                rem_d = `BAU_RST_BYTE;
                                quo_d = acc_q;
                            end
                        end
                        default: ;
                    endcase
                end
            end
            BAU_ST_DIV: begin
                // restoring divide, one quotient bit per clock
                if (trial[8]) begin
                    rem_d = {rem_q[6:0], quo_q[7]};
                    quo_d = {quo_q[6:0], 1'b0};
                end else begin
                    rem_d = trial[7:0];
                    quo_d = {quo_q[6:0], 1'b1};
                end
                cnt_d = cnt_q - 4'h1;
                if (cnt_q == 4'h1) begin
                    // quotient, remainder and flags land together
                    acc_d    = quo_d;
                    mdreg_d  = rem_d;
                    // carry cleared with the results, not at the start
                    flg_d.cy = 1'b0;
                    flg_d.ov = 1'b0;
                    st_d     = BAU_ST_IDLE;
                    done_d   = 1'b1;
                end
            end
            default: st_d = BAU_ST_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge I_MCLK) begin
        if (!I_NRST) begin
            acc_q     <= 8'h00;
            mdreg_q   <= 8'h00;
            imm_q     <= 8'h00;
            src_q     <= BAU_SRC_IMM;
            flg_q     <= 3'h0;
            st_q      <= BAU_ST_IDLE;
            cnt_q     <= 4'h0;
            rem_q     <= 8'h00;
            quo_q     <= 8'h00;
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            done_q    <= 1'b0;
        end else begin
            acc_q     <= acc_d;
            mdreg_q   <= mdreg_d;
            imm_q     <= imm_d;
            src_q     <= src_d;
            flg_q     <= flg_d;
            st_q      <= st_d;
            cnt_q     <= cnt_d;
            rem_q     <= rem_d;
            quo_q     <= quo_d;
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
            done_q    <= done_d;
        end
    end

    assign O_PRDATA  = prdata_q;
    assign O_PREADY  = pready_q;
    assign O_PSLVERR = pslverr_q;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_NRST);

    sequence go_s(bau_op_t o);
        st_q == BAU_ST_IDLE && wr_ctrl && I_PWDATA[`BAU_CTRL_GO] && op == o;
    endsequence

    add_result_a: assert property (go_s(BAU_OP_ADD) |=> acc_q == 8'($past(acc_q) + $past(opnd)))
        else $error("add result wrong");
    src_sel_a: assert property (src_q == BAU_SRC_IMM |-> opnd == imm_q)
        else $error("immediate source not selected");
    sum_with_carry_op_carry_a: assert property (go_s(BAU_OP_SUM_WITH_CARRY_OP) |=> acc_q == 8'($past(acc_q) + $past(opnd) + $past(flg_q.cy)))
        else $error("add with carry result wrong");
    add_cy_a: assert property (go_s(BAU_OP_ADD) |=> flg_q.cy == (({1'b0, $past(acc_q)} + {1'b0, $past(opnd)}) > 9'h0FF))
        else $error("add carry wrong");
    add_ac_a: assert property (go_s(BAU_OP_ADD) |=> flg_q.ac == (($past(acc_q[3:0]) + $past(opnd[3:0])) > 5'h0F))
        else $error("add nibble carry wrong");
    add_ov_a: assert property (go_s(BAU_OP_ADD) ##1 ($past(acc_q[7]) == $past(opnd[7])) |-> flg_q.ov == (acc_q[7] != $past(acc_q[7])))
        else $error("add overflow wrong");
    sub_cy_a: assert property (go_s(BAU_OP_DIFFERENCE_WITH_BORROW_OP) |=> flg_q.cy == ({1'b0, $past(acc_q)} < ({1'b0, $past(opnd)} + $past(flg_q.cy))))
        else $error("subtract borrow wrong");
    sub_res_a: assert property (go_s(BAU_OP_DIFFERENCE_WITH_BORROW_OP) |=> acc_q == 8'($past(acc_q) - $past(opnd) - $past(flg_q.cy)))
        else $error("subtract result wrong");
    sub_ac_a: assert property (go_s(BAU_OP_DIFFERENCE_WITH_BORROW_OP) |=> flg_q.ac == ({1'b0, $past(acc_q[3:0])} < ({1'b0, $past(opnd[3:0])} + $past(flg_q.cy))))
        else $error("subtract nibble borrow wrong");
    property sub_ov_p;
        go_s(BAU_OP_DIFFERENCE_WITH_BORROW_OP) |=> flg_q.ov == (($past(acc_q[7]) != $past(opnd[7])) && (acc_q[7] != $past(acc_q[7])));
    endproperty
    sub_ov_a: assert property (sub_ov_p)
        else $error("subtract overflow wrong");
    mul_prod_a: assert property (go_s(BAU_OP_MUL) |=> {mdreg_q, acc_q} == $past(acc_q) * $past(mdreg_q))
        else $error("multiply product wrong");
    mul_flags_a: assert property (go_s(BAU_OP_MUL) |=> !flg_q.cy && flg_q.ov == (mdreg_q != 8'h00) && flg_q.ac == $past(flg_q.ac))
        else $error("multiply flags wrong");
    div_zero_a: assert property (go_s(BAU_OP_DIV) ##0 mdreg_q == 8'h00 |=> flg_q.ov && !flg_q.cy && st_q == BAU_ST_IDLE)
        else $error("divide by zero flags wrong");
    div_done_a: assert property (go_s(BAU_OP_DIV) ##0 mdreg_q != 8'h00 |=> st_q == BAU_ST_DIV [*8] ##1 (st_q == BAU_ST_IDLE && !flg_q.ov && !flg_q.cy && done_q))
        else $error("divide did not finish in eight steps");
    // Divisor and dividend stay put in B and the accumulator until the last step
    property div_identity_p;
        st_q == BAU_ST_DIV && cnt_q == 4'h1 |=> mdreg_q < $past(mdreg_q) &&
            16'(acc_q) * 16'($past(mdreg_q)) + 16'(mdreg_q) == 16'($past(acc_q));
    endproperty
    div_res_a: assert property (div_identity_p)
        else $error("divide quotient and remainder wrong");

endmodule
`default_nettype wire

/* File: verification/bau_fetch_model.sv */
// Operand fetch model: direct RAM bytes and working registers for the unit
`timescale 1ns/10ps
`default_nettype none
module bau_fetch_model
    import bau_pkg::*;
(
    // Clock
    input  wire logic       i_mclk,
    // Loading of the direct RAM
    input  wire logic       i_ram_we,
    input  wire logic [3:0] i_ram_addr,
    input  wire logic [7:0] i_ram_wdata,
    // Working register select
    input  wire logic [2:0] i_reg_sel,
    // Operands towards the unit
    output logic [7:0]      o_ram_byte,
    output logic [7:0]      o_work_reg
);
    logic [7:0] ram_q [16];
    initial begin
        for (int i = 0; i < 16; i++) begin
            ram_q[i] = 8'(i) ^ 8'ha5;
        end
    end
    always @(posedge i_mclk) begin
        if (i_ram_we) begin
            ram_q[i_ram_addr] <= i_ram_wdata;
        end
    end
    // operands as levels
    // Levels, not pulses: the unit samples them through synchronisers
    assign o_ram_byte = ram_q[i_ram_addr];
    assign o_work_reg = {i_reg_sel, 5'h0b};
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
// Self-checking bench of the byte arithmetic unit over its register bus
`timescale 1ns/10ps
`default_nettype none
`include "bau_consts.svh"
module testbench
    import bau_pkg::*;
;
    localparam int TIMEOUT_CYC = 6000;
    logic         mclk;
    logic         nrst;
    bau_apb_req_t req;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    logic [7:0]   ram_byte;
    logic [7:0]   work_reg;
    logic         ram_we;
    logic [3:0]   ram_addr;
    logic [7:0]   ram_wdata;
    logic [2:0]   reg_sel;
    logic [31:0]  d;
    logic         e;
    int           n_errors;
    int           n_compared;
    int           cyc;
    bau_unit i_bau_unit (.I_MCLK(mclk), .I_NRST(nrst), .I_PADDR(req.paddr), .I_PSEL(req.psel),
        .I_PENABLE(req.penable), .I_PWRITE(req.pwrite), .I_PWDATA(req.pwdata), .I_RAM_BYTE(ram_byte),
        .I_WORK_REG(work_reg), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr));
    bau_fetch_model i_bau_fetch_model (.i_mclk(mclk), .i_ram_we(ram_we), .i_ram_addr(ram_addr),
        .i_ram_wdata(ram_wdata), .i_reg_sel(reg_sel), .o_ram_byte(ram_byte), .o_work_reg(work_reg));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("checks: %0d compared, %0d errors", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == TIMEOUT_CYC) begin
            n_errors = n_errors + 1;
            end_sim();
        end
    end
    task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic chk_bit(input string name, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %b seen %b", name, exp, got);
        end
    endtask
    // Held from setup until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd_v, output logic err);
        @(posedge mclk);
        req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: wd};
        @(posedge mclk);
        req.penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd_v = prdata;
        err = pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] wd);
        apb(1'b1, a, wd, d, e);
        chk_bit("write error", 1'b0, e);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000, d, e);
        chk_word($sformatf("reg %h", a), exp, d);
        chk_bit("read error", 1'b0, e);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic start(input bau_op_t op, input bau_src_t src, input logic [7:0] a,
                         input logic [7:0] imm, input logic [7:0] md, input logic [2:0] f);
        int n;
        wr(`BAU_OFF_ACC, {24'h00_0000, a});
        wr(`BAU_OFF_MDREG, {24'h00_0000, md});
        wr(`BAU_OFF_FLAGS, {29'h0000_0000, f});
        wr(`BAU_OFF_OPERAND, {22'h00_0000, src, imm});
        wr(`BAU_OFF_CTRL, {28'h000_0000, 1'b1, op});
        n = 0;
        d = 32'h0000_0008;
        while (d[`BAU_FLD_BUSY] !== 1'b0 && n < 20) begin
            apb(1'b0, `BAU_OFF_FLAGS, 32'h0000_0000, d, e);
            n++;
        end
        chk_bit("busy", 1'b0, d[`BAU_FLD_BUSY]);
    endtask
    // Non-immediate sources get an inverted immediate, so a wrong source shows
    task automatic arith(input bau_op_t op, input bau_src_t src, input logic [7:0] a,
                         input logic [7:0] v, input logic cin);
        logic [8:0] r;
        logic       c;
        logic       h;
        logic       s6;
        c = (op == BAU_OP_ADD) ? 1'b0 : cin;
        if (op == BAU_OP_DIFFERENCE_WITH_BORROW_OP) begin
            r = {1'b0, a} - {1'b0, v} - 9'(c);
            h = {1'b0, a[3:0]} < ({1'b0, v[3:0]} + 5'(c));
            s6 = {1'b0, a[6:0]} < ({1'b0, v[6:0]} + 8'(c));
        end else begin
            r = {1'b0, a} + {1'b0, v} + 9'(c);
            h = ({1'b0, a[3:0]} + {1'b0, v[3:0]} + 5'(c)) > 5'h0f;
            s6 = ({1'b0, a[6:0]} + {1'b0, v[6:0]} + 8'(c)) > 8'h7f;
        end
        start(op, src, a, (src == BAU_SRC_IMM) ? v : ~v, 8'h00, {2'b00, cin});
        rd(`BAU_OFF_ACC, {24'h00_0000, r[7:0]});
        rd(`BAU_OFF_FLAGS, {29'h0000_0000, r[8] ^ s6, h, r[8]});
    endtask
    task automatic muldiv(input bau_op_t op, input logic [7:0] a, input logic [7:0] b, input logic [2:0] f);
        logic [15:0] p;
        logic        ov;
        p = (op == BAU_OP_MUL) ? a * b : ((b != 8'h00) ? {a % b, a / b} : 16'h0000);
        ov = (op == BAU_OP_MUL) ? (p > 16'h00ff) : (b == 8'h00);
        start(op, BAU_SRC_IMM, a, 8'h00, b, f);
        if (op == BAU_OP_MUL || b != 8'h00) begin
            rd(`BAU_OFF_ACC, {24'h00_0000, p[7:0]});
            rd(`BAU_OFF_MDREG, {24'h00_0000, p[15:8]});
        end
        rd(`BAU_OFF_FLAGS, {29'h0000_0000, ov, f[1], 1'b0});
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        req = '0;
        nrst = 1'b0;
        ram_we = 1'b0;
        ram_addr = 4'h0;
        ram_wdata = 8'h00;
        reg_sel = 3'h0;
        n_errors = 0;
        n_compared = 0;
        cyc = 0;
        repeat (6) @(posedge mclk);
        nrst <= 1'b1;
        rd(`BAU_OFF_ACC, 32'h0000_0000);
        rd(`BAU_OFF_MDREG, 32'h0000_0000);
        rd(`BAU_OFF_FLAGS, 32'h0000_0000);
        apb(1'b0, 12'h080, 32'h0000_0000, d, e);
        chk_bit("unmapped error", 1'b1, e);
        chk_word("unmapped data", 32'h0000_0000, d);
        arith(BAU_OP_ADD, BAU_SRC_IMM, 8'hf0, 8'h20, 1'b1);
        arith(BAU_OP_ADD, BAU_SRC_IMM, 8'h2e, 8'h05, 1'b0);
        arith(BAU_OP_ADD, BAU_SRC_IMM, 8'h70, 8'h20, 1'b0);
        arith(BAU_OP_SUM_WITH_CARRY_OP, BAU_SRC_IMM, 8'hff, 8'h00, 1'b1);
        arith(BAU_OP_SUM_WITH_CARRY_OP, BAU_SRC_IMM, 8'h7f, 8'h00, 1'b1);
        // Carry left by one operation feeds the next one unchanged
        arith(BAU_OP_ADD, BAU_SRC_IMM, 8'hf0, 8'h20, 1'b0);
        wr(`BAU_OFF_ACC, 32'h0000_0000);
        wr(`BAU_OFF_OPERAND, 32'h0000_0000);
        wr(`BAU_OFF_CTRL, {28'h000_0000, 1'b1, BAU_OP_SUM_WITH_CARRY_OP});
        rd(`BAU_OFF_ACC, 32'h0000_0001);
        @(posedge mclk);
        ram_we <= 1'b1;
        ram_addr <= 4'h3;
        ram_wdata <= 8'h9c;
        @(posedge mclk);
        ram_we <= 1'b0;
        reg_sel <= 3'h5;
        arith(BAU_OP_ADD, BAU_SRC_RAM, 8'h11, 8'h9c, 1'b0);
        arith(BAU_OP_DIFFERENCE_WITH_BORROW_OP, BAU_SRC_REG, 8'h40, 8'hab, 1'b1);
        arith(BAU_OP_DIFFERENCE_WITH_BORROW_OP, BAU_SRC_IMM, 8'h38, 8'h06, 1'b1);
        arith(BAU_OP_DIFFERENCE_WITH_BORROW_OP, BAU_SRC_IMM, 8'h10, 8'h20, 1'b0);
        arith(BAU_OP_DIFFERENCE_WITH_BORROW_OP, BAU_SRC_IMM, 8'h80, 8'h01, 1'b0);
        arith(BAU_OP_DIFFERENCE_WITH_BORROW_OP, BAU_SRC_IMM, 8'h7f, 8'hff, 1'b0);
        muldiv(BAU_OP_MUL, 8'h20, 8'h75, 3'b011);
        muldiv(BAU_OP_MUL, 8'h03, 8'h04, 3'b001);
        muldiv(BAU_OP_DIV, 8'hf3, 8'h13, 3'b101);
        muldiv(BAU_OP_DIV, 8'hff, 8'h01, 3'b001);
        muldiv(BAU_OP_DIV, 8'h55, 8'h00, 3'b001);
        end_sim();
    end
endmodule
`default_nettype wire
